// >>> rtl/cmr_pkg.sv
`default_nettype none
package cmr_pkg;
   // Register addresses (7-bit register address space)
   localparam logic [6:0] ADDR_CHANNEL_PICK   = 7'h0A;
   localparam logic [6:0] ADDR_WAKEUP_CFG     = 7'h0B;
   localparam logic [6:0] ADDR_TRIM_ONE       = 7'h0C;
   localparam logic [6:0] ADDR_TRIM_TWO       = 7'h0D;
   localparam logic [6:0] ADDR_LOW_CELL_LIMIT = 7'h10;
   localparam logic [6:0] ADDR_SINGLE_RESULT  = 7'h11;
   localparam logic [6:0] ADDR_TRIM_THREE     = 7'h12;
   localparam logic [6:0] ADDR_CONTROL        = 7'h04;
   localparam logic [6:0] ADDR_IRQ_MASK       = 7'h05;
   localparam logic [6:0] ADDR_STATUS         = 7'h06;
   localparam logic [6:0] ADDR_LOW_CELL_FLAGS = 7'h08;

   // Reset values
   localparam logic [7:0]  RST_CHANNEL_PICK   = 8'h00;
   localparam logic [7:0]  RST_WAKEUP_CFG     = 8'hF9;
   localparam logic [7:0]  RST_TRIM_ONE       = 8'h03;
   localparam logic [7:0]  RST_TRIM_TWO       = 8'h07;
   localparam logic [11:0] RST_LOW_CELL_LIMIT = 12'h570;
   localparam logic [15:0] RST_TRIM_THREE     = 16'h0E00;

   // Field positions
   localparam int BIT_DIVIDER_SEL  = 7;
   localparam int BIT_RESTART      = 1;
   localparam int BIT_MASK_WAKEUP  = 1;
   localparam int BIT_MASK_LOWCELL = 3;
   localparam int BIT_ST_WAKEUP    = 1;
   localparam int BIT_ST_LOWCELL   = 3;

   // Channel selector codes
   localparam logic [2:0] SEL_TEMP  = 3'h6;
   localparam logic [2:0] SEL_TIMER = 3'h7;

   // Timer geometry: 4096 oscillator cycles per step, prescale 1 or 6
   localparam logic [11:0] STEP_CYCLES_M1  = 12'hFFF;
   localparam logic [2:0]  PRESCALE_OFF_M1 = 3'h0;
   localparam logic [2:0]  PRESCALE_ON_M1  = 3'h5;
   localparam int          OSC_HZ          = 50000;
   localparam int          STEP_NS         = 82000000;
   localparam int          CLOCK_PERIOD_NS = 8;
endpackage
`default_nettype wire

// >>> rtl/cmr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module cmr_regs (
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic        OSC_TICK,
   input  wire logic        TIMER_ENABLE,
   input  wire logic        REG_WRITE,
   input  wire logic        REG_READ,
   input  wire logic [6:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   output logic      [15:0] REG_RDATA,
   input  wire logic [71:0] CELL_RESULTS,
   input  wire logic [11:0] TEMP_RESULT,
   input  wire logic        RESULTS_VALID,
   output logic      [11:0] LOW_CELL_LIMIT,
   output logic             IRQ
);
   // Oscillator tick is asynchronous to CLOCK
   logic       tick_s1;
   logic       tick_s2;
   logic       tick_s3;
   logic       ena_s1;
   logic       ena_s2;
   logic       osc_edge;

   logic [2:0]  channel_pick;
   logic [7:0]  slow_wakeup_timer_cfg;
   logic [11:0] low_cell_limit;
   logic [11:0] single_result;
   logic [7:0]  trim_one;
   logic [7:0]  trim_two;
   logic [15:0] trim_three;
   logic [4:0]  irq_mask;
   logic [4:0]  status;
   logic [5:0]  low_cell_flags;
   logic [11:0] step_count;
   logic [2:0]  pre_count;
   logic [6:0]  wakeup_interval_count;

   logic [2:0]  next_channel_pick;
   logic [7:0]  next_cfg;
   logic [11:0] next_limit;
   logic [11:0] next_result;
   logic [7:0]  next_trim_one;
   logic [7:0]  next_trim_two;
   logic [15:0] next_trim_three;
   logic [4:0]  next_irq_mask;
   logic [4:0]  next_status;
   logic [5:0]  next_low_cell_flags;
   logic [11:0] next_step_count;
   logic [2:0]  next_pre_count;
   logic [6:0]  next_interval;
   logic [15:0] next_rdata;

   logic        wakeup_elapsed;
   logic        wakeup_restart;
   logic [5:0]  below;
   logic [2:0]  pre_max;
   logic [11:0] timer_value;
   logic        status_read;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tick_s1 <= 1'b0;
         tick_s2 <= 1'b0;
         tick_s3 <= 1'b0;
         ena_s1  <= 1'b0;
         ena_s2  <= 1'b0;
      end else begin
         tick_s1 <= OSC_TICK;
         tick_s2 <= tick_s1;
         tick_s3 <= tick_s2;
         ena_s1  <= TIMER_ENABLE;
         ena_s2  <= ena_s1;
      end
   end

   assign osc_edge = tick_s2 & ~tick_s3;

   // Timer: pre_count counts prescale, step_count counts 4096 oscillator cycles
   always_comb begin
      pre_max = slow_wakeup_timer_cfg[cmr_pkg::BIT_DIVIDER_SEL] ?
                cmr_pkg::PRESCALE_ON_M1 : cmr_pkg::PRESCALE_OFF_M1;
      wakeup_restart = REG_WRITE && (REG_ADDR == cmr_pkg::ADDR_CONTROL)
                       && REG_WDATA[cmr_pkg::BIT_RESTART];
      next_step_count = step_count;
      next_pre_count  = pre_count;
      next_interval   = wakeup_interval_count;
      wakeup_elapsed  = 1'b0;
      if (!ena_s2 || wakeup_restart) begin
         next_step_count = 12'h000;
         next_pre_count  = 3'h0;
         next_interval   = 7'h00;
      end else if (osc_edge) begin
         next_step_count = step_count + 12'h001;
         if (step_count == cmr_pkg::STEP_CYCLES_M1) begin
            next_pre_count = pre_count + 3'h1;
            if (pre_count >= pre_max) begin
               next_pre_count = 3'h0;
               next_interval  = wakeup_interval_count + 7'h01;
               if (wakeup_interval_count >= slow_wakeup_timer_cfg[6:0]) begin
                  next_interval  = 7'h00;
                  wakeup_elapsed = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         step_count            <= 12'h000;
         pre_count             <= 3'h0;
         wakeup_interval_count <= 7'h00;
      end else begin
         step_count            <= next_step_count;
         pre_count             <= next_pre_count;
         wakeup_interval_count <= next_interval;
      end
   end

   assign timer_value = {5'h00, wakeup_interval_count};

   // Register writes, result refresh and sticky status
   always_comb begin
      next_channel_pick   = channel_pick;
      next_cfg            = slow_wakeup_timer_cfg;
      next_limit          = low_cell_limit;
      next_result         = single_result;
      next_trim_one       = trim_one;
      next_trim_two       = trim_two;
      next_trim_three     = trim_three;
      next_irq_mask       = irq_mask;
      status_read         = REG_READ && (REG_ADDR == cmr_pkg::ADDR_STATUS);
      next_status         = status_read ? 5'h00 : status;
      next_low_cell_flags = low_cell_flags;
      for (int i = 0; i < 6; i++) begin
         below[i] = RESULTS_VALID && (CELL_RESULTS[i*12 +: 12] < low_cell_limit);
      end
      if (REG_WRITE) begin
         unique case (REG_ADDR)
            cmr_pkg::ADDR_CHANNEL_PICK: begin
               next_channel_pick = REG_WDATA[2:0];
               unique case (REG_WDATA[2:0])
                  cmr_pkg::SEL_TEMP:  next_result = TEMP_RESULT;
                  cmr_pkg::SEL_TIMER: next_result = timer_value;
                  default:            next_result = CELL_RESULTS[REG_WDATA[2:0]*12 +: 12];
               endcase
            end
            cmr_pkg::ADDR_WAKEUP_CFG:     next_cfg = REG_WDATA[7:0];
            cmr_pkg::ADDR_LOW_CELL_LIMIT: next_limit = REG_WDATA[11:0];
            cmr_pkg::ADDR_IRQ_MASK:       next_irq_mask = REG_WDATA[4:0];
            cmr_pkg::ADDR_TRIM_ONE:       next_trim_one = REG_WDATA[7:0];
            cmr_pkg::ADDR_TRIM_TWO:       next_trim_two = REG_WDATA[7:0];
            cmr_pkg::ADDR_TRIM_THREE:     next_trim_three = REG_WDATA;
            default: ;
         endcase
      end
      // Set wins over the clearing read
      if (wakeup_elapsed) begin
         next_status[cmr_pkg::BIT_ST_WAKEUP] = 1'b1;
      end
      if (|below) begin
         next_status[cmr_pkg::BIT_ST_LOWCELL] = 1'b1;
      end
      if (REG_READ && (REG_ADDR == cmr_pkg::ADDR_LOW_CELL_FLAGS)) begin
         next_low_cell_flags = 6'h00;
      end
      next_low_cell_flags = next_low_cell_flags | below;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         channel_pick          <= cmr_pkg::RST_CHANNEL_PICK[2:0];
         slow_wakeup_timer_cfg <= cmr_pkg::RST_WAKEUP_CFG;
         low_cell_limit        <= cmr_pkg::RST_LOW_CELL_LIMIT;
         single_result         <= 12'h000;
         trim_one              <= cmr_pkg::RST_TRIM_ONE;
         trim_two              <= cmr_pkg::RST_TRIM_TWO;
         trim_three            <= cmr_pkg::RST_TRIM_THREE;
         irq_mask              <= 5'h00;
         status                <= 5'h00;
         low_cell_flags        <= 6'h00;
      end else begin
         channel_pick          <= next_channel_pick;
         slow_wakeup_timer_cfg <= next_cfg;
         low_cell_limit        <= next_limit;
         single_result         <= next_result;
         trim_one              <= next_trim_one;
         trim_two              <= next_trim_two;
         trim_three            <= next_trim_three;
         irq_mask              <= next_irq_mask;
         status                <= next_status;
         low_cell_flags        <= next_low_cell_flags;
      end
   end

   // Read data is registered one cycle after the read strobe
   always_comb begin
      next_rdata = 16'h0000;
      if (REG_READ) begin
         unique case (REG_ADDR)
            cmr_pkg::ADDR_CHANNEL_PICK:   next_rdata = {13'h0000, channel_pick};
            cmr_pkg::ADDR_WAKEUP_CFG:     next_rdata = {8'h00,
               slow_wakeup_timer_cfg[cmr_pkg::BIT_DIVIDER_SEL], slow_wakeup_timer_cfg[6:0]};
            cmr_pkg::ADDR_LOW_CELL_LIMIT: next_rdata = {4'h0, low_cell_limit};
            cmr_pkg::ADDR_SINGLE_RESULT:  next_rdata = {4'h0, single_result};
            cmr_pkg::ADDR_IRQ_MASK:       next_rdata = {11'h000, irq_mask};
            cmr_pkg::ADDR_STATUS:         next_rdata = {11'h000, status};
            cmr_pkg::ADDR_LOW_CELL_FLAGS: next_rdata = {10'h000, low_cell_flags};
            cmr_pkg::ADDR_TRIM_ONE:       next_rdata = {8'h00, trim_one};
            cmr_pkg::ADDR_TRIM_TWO:       next_rdata = {8'h00, trim_two};
            cmr_pkg::ADDR_TRIM_THREE:     next_rdata = trim_three;
            default:                      next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         REG_RDATA <= 16'h0000;
      end else begin
         REG_RDATA <= next_rdata;
      end
   end

   assign LOW_CELL_LIMIT = low_cell_limit;
   assign IRQ = |(status & ~irq_mask);

   pick_refresh_a: assert property (@(posedge CLOCK) disable iff (RST)
      REG_WRITE && REG_ADDR == cmr_pkg::ADDR_CHANNEL_PICK && REG_WDATA[2:0] < cmr_pkg::SEL_TEMP
      |=> single_result == $past(CELL_RESULTS[REG_WDATA[2:0]*12 +: 12]))
      else $error("single result not refreshed from cell");
   pick_temp_a: assert property (@(posedge CLOCK) disable iff (RST)
      REG_WRITE && REG_ADDR == cmr_pkg::ADDR_CHANNEL_PICK && REG_WDATA[2:0] == cmr_pkg::SEL_TEMP
      |=> single_result == $past(TEMP_RESULT))
      else $error("temperature not routed");
   pick_timer_a: assert property (@(posedge CLOCK) disable iff (RST)
      REG_WRITE && REG_ADDR == cmr_pkg::ADDR_CHANNEL_PICK && REG_WDATA[2:0] == cmr_pkg::SEL_TIMER
      |=> single_result == {5'h00, $past(wakeup_interval_count)})
      else $error("timer value not routed");
   result_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
      !(REG_WRITE && REG_ADDR == cmr_pkg::ADDR_CHANNEL_PICK) |=> $stable(single_result))
      else $error("single result changed without selector write");
   result_upper_a: assert property (@(posedge CLOCK) disable iff (RST)
      $past(REG_READ) && $past(REG_ADDR) == cmr_pkg::ADDR_SINGLE_RESULT |-> REG_RDATA[15:12] == 4'h0)
      else $error("result upper bits not zero");
   wake_irq_a: assert property (@(posedge CLOCK) disable iff (RST)
      wakeup_elapsed && !irq_mask[cmr_pkg::BIT_MASK_WAKEUP] && !REG_WRITE |=> IRQ)
      else $error("elapse raised no interrupt");
   status_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
      status_read && !wakeup_elapsed && !(|below) |=> status == 5'h00)
      else $error("status read did not clear");
   restart_zero_a: assert property (@(posedge CLOCK) disable iff (RST)
      wakeup_restart |=> step_count == 12'h000 && wakeup_interval_count == 7'h00)
      else $error("restart did not clear timer");
   lowcell_flag_a: assert property (@(posedge CLOCK) disable iff (RST)
      |below |=> status[cmr_pkg::BIT_ST_LOWCELL] && (low_cell_flags & $past(below)) == $past(below))
      else $error("low cell not flagged");
   pick_store_a: assert property (@(posedge CLOCK) disable iff (RST)
      REG_WRITE && REG_ADDR == cmr_pkg::ADDR_CHANNEL_PICK
      |=> channel_pick == $past(REG_WDATA[2:0]))
      else $error("selector code not stored");
   pick_read_a: assert property (@(posedge CLOCK) disable iff (RST)
      $past(REG_READ) && $past(REG_ADDR) == cmr_pkg::ADDR_CHANNEL_PICK
      |-> REG_RDATA[15:3] == 13'h0000)
      else $error("selector upper bits not zero");
   limit_store_a: assert property (@(posedge CLOCK) disable iff (RST)
      REG_WRITE && REG_ADDR == cmr_pkg::ADDR_LOW_CELL_LIMIT
      |=> LOW_CELL_LIMIT == $past(REG_WDATA[11:0]))
      else $error("limit not stored");
   cfg_store_a: assert property (@(posedge CLOCK) disable iff (RST)
      REG_WRITE && REG_ADDR == cmr_pkg::ADDR_WAKEUP_CFG
      |=> slow_wakeup_timer_cfg == $past(REG_WDATA[7:0]))
      else $error("timer config not stored");
   delay_read_a: assert property (@(posedge CLOCK) disable iff (RST)
      REG_READ && REG_ADDR == cmr_pkg::ADDR_WAKEUP_CFG
      |=> REG_RDATA[6:0] == $past(slow_wakeup_timer_cfg[6:0]))
      else $error("delay field read differs from value in use");
   timer_reload_a: assert property (@(posedge CLOCK) disable iff (RST)
      wakeup_elapsed |=> wakeup_interval_count == 7'h00)
      else $error("timer did not reload after elapse");
   timer_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
      !ena_s2 |=> step_count == 12'h000 && wakeup_interval_count == 7'h00)
      else $error("disabled timer kept counting");
   lowcell_irq_a: assert property (@(posedge CLOCK) disable iff (RST)
      status[cmr_pkg::BIT_ST_LOWCELL] && !irq_mask[cmr_pkg::BIT_MASK_LOWCELL] |-> IRQ)
      else $error("unmasked low cell raised no interrupt");
endmodule
`default_nettype wire

// >>> bench/cmr_host.sv
`timescale 1ns/100ps
`default_nettype none
module cmr_host (
   input  wire logic        clock,
   output logic             reg_write,
   output logic             reg_read,
   output logic      [6:0]  reg_addr,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata
);
   // 100 us at 8 ns; closer timer config writes risk a corrupt delay decode
   localparam int CFG_GAP_CYCLES = 12500;
   longint last_cfg = -12500;
   longint cycle = 0;

   initial begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 7'h7F;
      reg_wdata = 16'hFFFF;
   end

   always @(posedge clock) begin
      cycle <= cycle + 1;
   end

   task automatic wr(input logic [6:0] addr, input logic [15:0] data);
      if (addr inside {cmr_pkg::ADDR_TRIM_ONE, cmr_pkg::ADDR_TRIM_TWO,
                       cmr_pkg::ADDR_TRIM_THREE}) begin
         return;
      end
      if (addr == cmr_pkg::ADDR_WAKEUP_CFG) begin
         while (cycle - last_cfg < CFG_GAP_CYCLES) @(negedge clock);
         last_cfg = cycle;
      end
      @(negedge clock);
      reg_addr = addr;
      reg_wdata = data;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
      // Released lines toggle so a stale value is never mistaken for a live one
      reg_addr = ~addr;
      reg_wdata = ~data;
   endtask

   task automatic rd(input logic [6:0] addr, output logic [15:0] data);
      @(negedge clock);
      reg_addr = addr;
      reg_read = 1'b1;
      @(negedge clock);
      // Read data stands only in the cycle after the strobe
      data = reg_rdata;
      reg_read = 1'b0;
      reg_addr = ~addr;
   endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        CLOCK, RST, OSC_TICK, TIMER_ENABLE, RESULTS_VALID, IRQ;
   logic        REG_WRITE, REG_READ;
   logic [6:0]  REG_ADDR;
   logic [15:0] REG_WDATA, REG_RDATA, rd_val;
   logic [71:0] CELL_RESULTS;
   logic [11:0] TEMP_RESULT, LOW_CELL_LIMIT;
   // Expected single result per selector code; the timer row reads 0 while disabled
   logic [11:0] exp_val [8] = '{12'h13C, 12'h23C, 12'h33C, 12'h43C, 12'h53C, 12'h63C,
                               12'hE5A, 12'h000};
   int          errors = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          n;

   cmr_regs cmr_regs_inst (.CLOCK(CLOCK), .RST(RST), .OSC_TICK(OSC_TICK),
      .TIMER_ENABLE(TIMER_ENABLE), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .CELL_RESULTS(CELL_RESULTS), .TEMP_RESULT(TEMP_RESULT),
      .RESULTS_VALID(RESULTS_VALID), .LOW_CELL_LIMIT(LOW_CELL_LIMIT), .IRQ(IRQ));

   cmr_host cmr_host_inst (.clock(CLOCK), .reg_write(REG_WRITE), .reg_read(REG_READ),
      .reg_addr(REG_ADDR), .reg_wdata(REG_WDATA), .reg_rdata(REG_RDATA));

   initial begin
      CLOCK = 1'b0;
      forever #4 CLOCK = ~CLOCK;
   end

   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 80000) begin
         errors++;
         final_report();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rd_chk(input logic [6:0] addr, input logic [15:0] exp);
      cmr_host_inst.rd(addr, rd_val);
      check(rd_val, exp);
   endtask

   task automatic status_chk(input logic [15:0] exp);
      cmr_host_inst.rd(cmr_pkg::ADDR_STATUS, rd_val);
      check(rd_val & 16'h000A, exp);
   endtask

   // Tick is slower than the two-stage synchroniser plus edge detect
   task automatic ticks(input int count);
      repeat (count) begin
         repeat (2) @(negedge CLOCK);
         OSC_TICK = 1'b1;
         repeat (3) @(negedge CLOCK);
         OSC_TICK = 1'b0;
      end
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      RST = 1'b1;
      OSC_TICK = 1'b0;
      TIMER_ENABLE = 1'b0;
      RESULTS_VALID = 1'b0;
      TEMP_RESULT = exp_val[6];
      CELL_RESULTS = {exp_val[5], exp_val[4], exp_val[3], exp_val[2], exp_val[1], exp_val[0]};
      repeat (2) @(negedge CLOCK);
      RST = 1'b0;
      check({4'h0, LOW_CELL_LIMIT}, 16'h0570);
      check({15'h0, IRQ}, 16'h0000);
      rd_chk(cmr_pkg::ADDR_WAKEUP_CFG, 16'h00F9);
      rd_chk(cmr_pkg::ADDR_LOW_CELL_LIMIT, 16'h0570);
      rd_chk(cmr_pkg::ADDR_CHANNEL_PICK, 16'h0000);
      rd_chk(cmr_pkg::ADDR_TRIM_ONE, 16'h0003);
      rd_chk(cmr_pkg::ADDR_TRIM_TWO, 16'h0007);
      rd_chk(cmr_pkg::ADDR_TRIM_THREE, 16'h0E00);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         cmr_host_inst.wr(cmr_pkg::ADDR_CHANNEL_PICK, 16'h00F8 | 16'(i));
         rd_chk(cmr_pkg::ADDR_SINGLE_RESULT, {4'h0, exp_val[i]});
         rd_chk(cmr_pkg::ADDR_CHANNEL_PICK, 16'(i));
      end
      $display("test selector table done");
      cmr_host_inst.wr(cmr_pkg::ADDR_CHANNEL_PICK, 16'h0001);
      CELL_RESULTS[23:12] = 12'h7A5;
      cmr_host_inst.wr(cmr_pkg::ADDR_CHANNEL_PICK, 16'h0001);
      rd_chk(cmr_pkg::ADDR_SINGLE_RESULT, 16'h07A5);
      cmr_host_inst.wr(7'h7E, 16'hFFFF);
      rd_chk(7'h7E, 16'h0000);
      $display("test refresh and unmapped done");
      cmr_host_inst.wr(cmr_pkg::ADDR_LOW_CELL_LIMIT, 16'hF200);
      rd_chk(cmr_pkg::ADDR_LOW_CELL_LIMIT, 16'h0200);
      check({4'h0, LOW_CELL_LIMIT}, 16'h0200);
      cmr_host_inst.wr(cmr_pkg::ADDR_IRQ_MASK, 16'h0000);
      RESULTS_VALID = 1'b1;
      repeat (4) @(negedge CLOCK);
      RESULTS_VALID = 1'b0;
      check({15'h0, IRQ}, 16'h0001);
      rd_chk(cmr_pkg::ADDR_LOW_CELL_FLAGS, 16'h0001);
      cmr_host_inst.wr(cmr_pkg::ADDR_IRQ_MASK, 16'h0008);
      check({15'h0, IRQ}, 16'h0000);
      status_chk(16'h0008);
      cmr_host_inst.wr(cmr_pkg::ADDR_IRQ_MASK, 16'h0000);
      check({15'h0, IRQ}, 16'h0000);
      $display("test undervoltage done");
      cmr_host_inst.wr(cmr_pkg::ADDR_WAKEUP_CFG, 16'h0000);
      TIMER_ENABLE = 1'b1;
      repeat (4) @(negedge CLOCK);
      cmr_host_inst.wr(cmr_pkg::ADDR_CONTROL, 16'h0002);
      rd_chk(cmr_pkg::ADDR_WAKEUP_CFG, 16'h0000);
      n = 0;
      while (IRQ !== 1'b1 && n < 4200) begin
         ticks(1);
         n++;
      end
      check({15'h0, (n inside {4096, 4097})}, 16'h0001);
      status_chk(16'h0002);
      check({15'h0, IRQ}, 16'h0000);
      cmr_host_inst.wr(cmr_pkg::ADDR_IRQ_MASK, 16'h0002);
      ticks(4100);
      check({15'h0, IRQ}, 16'h0000);
      status_chk(16'h0002);
      $display("test wakeup timer done");
      cmr_host_inst.wr(cmr_pkg::ADDR_WAKEUP_CFG, 16'h0080);
      cmr_host_inst.wr(cmr_pkg::ADDR_CONTROL, 16'h0002);
      status_chk(16'h0000);
      ticks(4200);
      status_chk(16'h0000);
      rd_chk(cmr_pkg::ADDR_WAKEUP_CFG, 16'h0080);
      $display("test prescaler done");
      RST = 1'b1;
      repeat (2) @(negedge CLOCK);
      RST = 1'b0;
      check({4'h0, LOW_CELL_LIMIT}, 16'h0570);
      check({15'h0, IRQ}, 16'h0000);
      rd_chk(cmr_pkg::ADDR_WAKEUP_CFG, 16'h00F9);
      rd_chk(cmr_pkg::ADDR_SINGLE_RESULT, 16'h0000);
      $display("test mid-run reset done");
      final_report();
   end
endmodule
`default_nettype wire
